// File: hw/psat_pkg.sv
/*
 * Constants, operation codes and widths for the packed add, subtract
 * and bit-test datapath.
 * Assumes the core issue logic drives an operation code of this type.
 */
// Overview of operation
// - Halving add-sub exchange: top = (a.top + b.bot) / 2
// - Halving add-sub exchange: bottom = (a.bot - b.top) / 2
// - Halving sub-add exchange: top = (a.top - b.bot) / 2
// - Halving sub-add exchange: bottom = (a.bot + b.top) / 2
// - Halving halfword subtract, each lane halved
// - Halving byte subtract, four lanes halved
// - Packed halfword subtract, two independent signed lanes
// - Packed byte subtract, four independent signed lanes
// - Add-sub exchange top = a.top + b.bot, unhalved
// - Add-sub exchange bottom = a.bot - b.top, unhalved
// - Packed operations never touch the condition flags
// - AND test sets flags, writes no register
// - XOR test sets flags, writes no register
// - Tests set N, Z; C from shifter; V untouched
// - After XOR test, N is XOR of signs
// - Unsigned halfword add, two independent lanes
// - Unsigned byte add, four independent lanes
package psat_pkg;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int HALF_LANES = 2;
	localparam int BYTE_LANES = 4;
	localparam int REG_IDX_W = 4;
	localparam int SIGN_BIT = 31;
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam logic [3:0] INDEX_RST = 4'h0;

	typedef enum logic [3:0] {
		op_signed_halving_add_sub_exchange,
		op_signed_halving_sub_add_exchange,
		op_signed_halving_halfword_subtract,
		op_signed_halving_byte_subtract,
		op_signed_packed_halfword_subtract,
		op_signed_packed_byte_subtract,
		op_signed_add_sub_exchange,
		op_signed_sub_add_exchange,
		op_and_bit_test,
		op_xor_equivalence_test,
		op_unsigned_packed_halfword_add,
		op_unsigned_packed_byte_add
	} psat_op_e;
endpackage

// File: hw/psat_lane.sv
/*
 * One packed lane: add or subtract, signed or unsigned, optionally halved.
 * Assumes operands and controls are stable within the cycle; purely combinational.
 */
`timescale 1ns/100ps
module psat_lane #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic sub,
	input wire logic halve,
	input wire logic is_signed,
	output logic [W-1:0] y
);
	logic [W:0] wide_a;
	logic [W:0] wide_b;
	logic [W:0] wide_r;

	// Extra top bit keeps the true value so the halved result cannot overflow
	assign wide_a = {is_signed & a[W-1], a};
	assign wide_b = {is_signed & b[W-1], b};
	assign wide_r = sub ? (wide_a - wide_b) : (wide_a + wide_b);
	// Unhalved result simply drops the top bit, so it wraps inside the lane
	assign y = halve ? wide_r[W:1] : wide_r[W-1:0];
endmodule

// File: hw/psat_alu.sv
/*
 * Packed halfword/byte add-subtract and bit-test execution stage.
 * Result, destination and flag updates are registered one cycle after issue.
 * Assumes decode, conditional execution and the operand shifter are outside.
 */
`timescale 1ns/100ps
module psat_alu #(
	parameter int IDX_W = psat_pkg::REG_IDX_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire psat_pkg::psat_op_e op_sel,
	input wire logic [31:0] first_operand,
	input wire logic [31:0] second_operand,
	input wire logic shifter_carry_valid,
	input wire logic shifter_carry,
	input wire logic dest_given,
	input wire logic [IDX_W-1:0] dest_index,
	input wire logic [IDX_W-1:0] first_src_index,
	output logic wr_en,
	output logic [IDX_W-1:0] wr_index,
	output logic [31:0] wr_data,
	output logic flag_nz_wr,
	output logic flag_n,
	output logic flag_z,
	output logic flag_c_wr,
	output logic flag_c
);
	////////////////////////////////////////////////////////////////////////////
	// Decode
	logic legal;
	logic use_bytes;
	logic is_test;
	logic is_xor;
	logic hw_xchg;
	logic hw_halve;
	logic hw_signed;
	logic [1:0] hw_sub;
	logic by_sub;
	logic by_halve;
	logic by_signed;

	always_comb begin
		legal = 1'b1;
		use_bytes = 1'b0;
		is_test = 1'b0;
		is_xor = 1'b0;
		hw_xchg = 1'b0;
		hw_halve = 1'b0;
		hw_signed = 1'b1;
		hw_sub = 2'h0;
		by_sub = 1'b0;
		by_halve = 1'b0;
		by_signed = 1'b1;
		unique case (op_sel)
			psat_pkg::op_signed_halving_add_sub_exchange: begin
				hw_xchg = 1'b1;
				hw_halve = 1'b1;
				hw_sub = 2'h1;
			end
			psat_pkg::op_signed_halving_sub_add_exchange: begin
				hw_xchg = 1'b1;
				hw_halve = 1'b1;
				hw_sub = 2'h2;
			end
			psat_pkg::op_signed_halving_halfword_subtract: begin
				hw_halve = 1'b1;
				hw_sub = 2'h3;
			end
			psat_pkg::op_signed_halving_byte_subtract: begin
				use_bytes = 1'b1;
				by_sub = 1'b1;
				by_halve = 1'b1;
			end
			psat_pkg::op_signed_packed_halfword_subtract: begin
				hw_sub = 2'h3;
			end
			psat_pkg::op_signed_packed_byte_subtract: begin
				use_bytes = 1'b1;
				by_sub = 1'b1;
			end
			psat_pkg::op_signed_add_sub_exchange: begin
				hw_xchg = 1'b1;
				hw_sub = 2'h1;
			end
			psat_pkg::op_signed_sub_add_exchange: begin
				hw_xchg = 1'b1;
				hw_sub = 2'h2;
			end
			psat_pkg::op_and_bit_test: begin
				is_test = 1'b1;
			end
			psat_pkg::op_xor_equivalence_test: begin
				is_test = 1'b1;
				is_xor = 1'b1;
			end
			psat_pkg::op_unsigned_packed_halfword_add: begin
				hw_signed = 1'b0;
			end
			psat_pkg::op_unsigned_packed_byte_add: begin
				use_bytes = 1'b1;
				by_signed = 1'b0;
			end
			default: begin
				// Unused codes issue nothing at all
				legal = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Lanes
	logic [31:0] half_res;
	logic [31:0] byte_res;

	genvar gh;
	generate
		for (gh = 0; gh < psat_pkg::HALF_LANES; gh++) begin : g_half
			localparam int OTHER = psat_pkg::HALF_LANES - 1 - gh;
			logic [15:0] b_sel;
			// Exchange pairs each first-operand half with the opposite second half
			assign b_sel = hw_xchg ? second_operand[OTHER*psat_pkg::HALF_W +: psat_pkg::HALF_W]
				: second_operand[gh*psat_pkg::HALF_W +: psat_pkg::HALF_W];
			psat_lane #(
				.W(psat_pkg::HALF_W)
			) u_lane (
				.a(first_operand[gh*psat_pkg::HALF_W +: psat_pkg::HALF_W]),
				.b(b_sel),
				.sub(hw_sub[gh]),
				.halve(hw_halve),
				.is_signed(hw_signed),
				.y(half_res[gh*psat_pkg::HALF_W +: psat_pkg::HALF_W])
			);
		end
		for (gh = 0; gh < psat_pkg::BYTE_LANES; gh++) begin : g_byte
			psat_lane #(
				.W(psat_pkg::BYTE_W)
			) u_lane (
				.a(first_operand[gh*psat_pkg::BYTE_W +: psat_pkg::BYTE_W]),
				.b(second_operand[gh*psat_pkg::BYTE_W +: psat_pkg::BYTE_W]),
				.sub(by_sub),
				.halve(by_halve),
				.is_signed(by_signed),
				.y(byte_res[gh*psat_pkg::BYTE_W +: psat_pkg::BYTE_W])
			);
		end
	endgenerate

	logic [31:0] test_res;
	assign test_res = is_xor ? (first_operand ^ second_operand) : (first_operand & second_operand);

	////////////////////////////////////////////////////////////////////////////
	// Register write-back
	logic wr_en_q;
	logic [IDX_W-1:0] wr_index_q;
	logic [31:0] wr_data_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_en_q <= 1'b0;
		end else begin
			// Test operations discard their result
			wr_en_q <= op_valid & legal & ~is_test;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_index_q <= IDX_W'(psat_pkg::INDEX_RST);
			wr_data_q <= psat_pkg::RESULT_RST;
		end else if (op_valid & legal & ~is_test) begin
			wr_index_q <= dest_given ? dest_index : first_src_index;
			wr_data_q <= use_bytes ? byte_res : half_res;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag updates; overflow has no output so it can never be disturbed
	logic nz_wr_q;
	logic n_q;
	logic z_q;
	logic c_wr_q;
	logic c_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			nz_wr_q <= 1'b0;
			c_wr_q <= 1'b0;
		end else begin
			// Only tests raise flag writes; packed ops leave them clear
			nz_wr_q <= op_valid & is_test;
			c_wr_q <= op_valid & is_test & shifter_carry_valid;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			n_q <= 1'b0;
			z_q <= 1'b0;
			c_q <= 1'b0;
		end else if (op_valid & is_test) begin
			// For the XOR test this bit is the XOR of both sign bits
			n_q <= test_res[psat_pkg::SIGN_BIT];
			z_q <= (test_res == 32'h0000_0000);
			c_q <= shifter_carry;
		end
	end

	assign wr_en = wr_en_q;
	assign wr_index = wr_index_q;
	assign wr_data = wr_data_q;
	assign flag_nz_wr = nz_wr_q;
	assign flag_n = n_q;
	assign flag_z = z_q;
	assign flag_c_wr = c_wr_q;
	assign flag_c = c_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic [31:0] a;
	logic [31:0] b;
	logic [16:0] ex_top_sum;
	logic [16:0] ex_bot_dif;
	logic [16:0] ex_top_dif;
	logic [16:0] ex_bot_sum;
	logic [16:0] hs_bot_dif;
	logic [8:0] bs_b0_dif;
	logic [8:0] bs_b3_dif;
	assign a = first_operand;
	assign b = second_operand;
	assign ex_top_sum = {a[31], a[31:16]} + {b[15], b[15:0]};
	assign ex_bot_dif = {a[15], a[15:0]} - {b[31], b[31:16]};
	assign ex_top_dif = {a[31], a[31:16]} - {b[15], b[15:0]};
	assign ex_bot_sum = {a[15], a[15:0]} + {b[31], b[31:16]};
	assign hs_bot_dif = {a[15], a[15:0]} - {b[15], b[15:0]};
	assign bs_b0_dif = {a[7], a[7:0]} - {b[7], b[7:0]};
	assign bs_b3_dif = {a[31], a[31:24]} - {b[31], b[31:24]};

	chk_hasx_top: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_add_sub_exchange)
		|=> wr_en && wr_data[31:16] == $past(ex_top_sum[16:1]))
		else $error("halving exchange top lane wrong");
	chk_hasx_bottom: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_add_sub_exchange)
		|=> wr_data[15:0] == $past(ex_bot_dif[16:1]))
		else $error("halving exchange bottom lane wrong");
	chk_hsax_top: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_sub_add_exchange)
		|=> wr_data[31:16] == $past(ex_top_dif[16:1]))
		else $error("halving sub-add top lane wrong");
	chk_hsax_bottom: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_sub_add_exchange)
		|=> wr_data[15:0] == $past(ex_bot_sum[16:1]))
		else $error("halving sub-add bottom lane wrong");
	chk_hsub_half: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_halfword_subtract)
		|=> wr_data[15:0] == $past(hs_bot_dif[16:1]))
		else $error("halving halfword subtract wrong");
	chk_hsub_byte: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_byte_subtract)
		|=> wr_data[7:0] == $past(bs_b0_dif[8:1])
		&& wr_data[31:24] == $past(bs_b3_dif[8:1]))
		else $error("halving byte subtract wrong");
	chk_halving_wide: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_halving_halfword_subtract
		&& a[15:0] == 16'h7fff && b[15:0] == 16'h8000)
		|=> wr_data[15:0] == 16'h7fff)
		else $error("halving lane overflowed");
	chk_sub_half: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_packed_halfword_subtract)
		|=> wr_data == {$past(a[31:16] - b[31:16]), $past(a[15:0] - b[15:0])})
		else $error("packed halfword subtract wrong");
	chk_sub_byte: assert property ((op_valid && op_sel ==
		psat_pkg::op_signed_packed_byte_subtract)
		|=> wr_data[15:8] == $past(a[15:8] - b[15:8]))
		else $error("packed byte subtract wrong");
	chk_asx_top: assert property ((op_valid
		&& op_sel == psat_pkg::op_signed_add_sub_exchange)
		|=> wr_data[31:16] == $past(a[31:16] + b[15:0]))
		else $error("exchange top sum wrong");
	chk_asx_bottom: assert property ((op_valid
		&& op_sel == psat_pkg::op_signed_add_sub_exchange)
		|=> wr_data[15:0] == $past(a[15:0] - b[31:16]))
		else $error("exchange bottom difference wrong");
	chk_flags_kept: assert property (wr_en |-> !flag_nz_wr && !flag_c_wr)
		else $error("packed operation touched flags");
	chk_test_nowrite: assert property ((op_valid
		&& (op_sel == psat_pkg::op_and_bit_test
		|| op_sel == psat_pkg::op_xor_equivalence_test)) |=> !wr_en && flag_nz_wr)
		else $error("test wrote a register or skipped flags");
	chk_and_flags: assert property ((op_valid && op_sel == psat_pkg::op_and_bit_test)
		|=> flag_z == ($past(a & b) == 32'h0000_0000)
		&& flag_c_wr == $past(shifter_carry_valid))
		else $error("and test flags wrong");
	chk_xor_sign: assert property ((op_valid
		&& op_sel == psat_pkg::op_xor_equivalence_test)
		|=> flag_n == ($past(a[31]) ^ $past(b[31])))
		else $error("xor test sign flag wrong");
	chk_uadd_half: assert property ((op_valid && op_sel ==
		psat_pkg::op_unsigned_packed_halfword_add)
		|=> wr_data == {$past(a[31:16] + b[31:16]), $past(a[15:0] + b[15:0])})
		else $error("unsigned halfword add wrong");
	chk_uadd_byte: assert property ((op_valid
		&& op_sel == psat_pkg::op_unsigned_packed_byte_add)
		|=> wr_data[23:16] == $past(a[23:16] + b[23:16]))
		else $error("unsigned byte add wrong");
	chk_dest_default: assert property ((op_valid && legal && !is_test && !dest_given)
		|=> wr_index == $past(first_src_index))
		else $error("omitted destination not first source");

	cov_halving_exchange: cover property (op_valid
		&& op_sel == psat_pkg::op_signed_halving_add_sub_exchange ##1 wr_en);
	cov_xor_test_neg: cover property (op_valid
		&& op_sel == psat_pkg::op_xor_equivalence_test ##1 flag_n);
	cov_back_to_back: cover property (op_valid && !is_test ##1 op_valid && is_test);
	cov_byte_add_wrap: cover property (op_valid
		&& op_sel == psat_pkg::op_unsigned_packed_byte_add && a[7] && b[7]);
endmodule

// File: verification/psat_core_model.sv
/*
 * Core-side partner: register file and condition flags fed by the datapath.
 * Assumes the datapath write-back and flag strobes are one-cycle pulses.
 */
`timescale 1ns/100ps
module psat_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [3:0] wr_index,
	input wire logic [31:0] wr_data,
	input wire logic flag_nz_wr,
	input wire logic flag_n,
	input wire logic flag_z,
	input wire logic flag_c_wr,
	input wire logic flag_c
);
	logic [31:0] regs_q [0:15];
	logic [3:0] nzcv_q;
	logic bad_index_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs_q[i] <= 32'h0000_0000;
			end
		end else if (wr_en) begin
			regs_q[wr_index] <= wr_data;
		end
	end

	// Stack pointer and PC sit at 13..15; the issuer never names them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bad_index_q <= 1'b0;
		end else if (wr_en && wr_index > 4'hc) begin
			bad_index_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// V is never written: the datapath has no overflow output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			nzcv_q <= 4'h0;
		end else begin
			if (flag_nz_wr) begin
				nzcv_q[3:2] <= {flag_n, flag_z};
			end
			if (flag_c_wr) begin
				nzcv_q[1] <= flag_c;
			end
		end
	end
endmodule

// File: verification/psat_alu_tb_top.sv
/*
 * Self-checking bench for the packed add/subtract and bit-test datapath.
 * Assumes one op per issue, answers just after the taking edge.
 */
`timescale 1ns/100ps
module psat_alu_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0;
	psat_pkg::psat_op_e op_sel = psat_pkg::op_signed_halving_add_sub_exchange;
	logic [31:0] first_operand = 32'h0;
	logic [31:0] second_operand = 32'h0;
	logic shifter_carry_valid = 1'b0;
	logic shifter_carry = 1'b0;
	logic dest_given = 1'b0;
	logic [3:0] dest_index = 4'h0;
	logic [3:0] first_src_index = 4'h0;
	logic wr_en, flag_nz_wr, flag_n, flag_z, flag_c_wr, flag_c;
	logic [3:0] wr_index;
	logic [31:0] wr_data;
	int error_cnt = 0;
	int cmp_count = 0;
	int seed = 18;

	psat_alu DUT (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_sel(op_sel),
		.first_operand(first_operand), .second_operand(second_operand),
		.shifter_carry_valid(shifter_carry_valid), .shifter_carry(shifter_carry),
		.dest_given(dest_given), .dest_index(dest_index), .first_src_index(first_src_index),
		.wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data), .flag_nz_wr(flag_nz_wr),
		.flag_n(flag_n), .flag_z(flag_z), .flag_c_wr(flag_c_wr), .flag_c(flag_c));
	psat_core_model core (.sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .wr_index(wr_index),
		.wr_data(wr_data), .flag_nz_wr(flag_nz_wr), .flag_n(flag_n), .flag_z(flag_z),
		.flag_c_wr(flag_c_wr), .flag_c(flag_c));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask

	function automatic logic [15:0] ln(input logic [15:0] a, input logic [15:0] b,
		input int w, input bit sub, input bit hv, input bit sg);
		int m, x, y, r;
		m = 1 << (w - 1);
		x = sg ? ((int'(a) ^ m) - m) : int'(a);
		y = sg ? ((int'(b) ^ m) - m) : int'(b);
		r = sub ? x - y : x + y;
		// Full-precision int first, so halving never loses the lane's carry
		if (hv) r = r >>> 1;
		return r[15:0];
	endfunction

	function automatic logic [31:0] exp_data(input logic [3:0] op, input logic [31:0] a,
		input logic [31:0] b);
		bit xc, ts, bs, hv, sg, by;
		logic [15:0] bt, bb, t;
		logic [31:0] r;
		{xc, ts, bs, hv, sg, by} = 6'h00;
		case (op)
			4'h0: {xc, ts, bs, hv, sg} = 5'b10111;
			4'h1: {xc, ts, bs, hv, sg} = 5'b11011;
			4'h2: {ts, bs, hv, sg} = 4'b1111;
			4'h3: {ts, bs, hv, sg, by} = 5'b11111;
			4'h4: {ts, bs, sg} = 3'b111;
			4'h5: {ts, bs, sg, by} = 4'b1111;
			4'h6: {xc, bs, sg} = 3'b111;
			4'h7: {xc, ts, sg} = 3'b111;
			4'hb: by = 1'b1;
			default: ;
		endcase
		if (by) begin
			for (int i = 0; i < 4; i++) begin
				t = ln({8'h00, a[8*i+:8]}, {8'h00, b[8*i+:8]}, 8, ts, hv, sg);
				r[8*i+:8] = t[7:0];
			end
		end else begin
			bt = xc ? b[15:0] : b[31:16];
			bb = xc ? b[31:16] : b[15:0];
			r[31:16] = ln(a[31:16], bt, 16, ts, hv, sg);
			r[15:0] = ln(a[15:0], bb, 16, bs, hv, sg);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic dg, input logic [3:0] di, input logic [3:0] si, input logic cv,
		input logic c);
		logic [31:0] ex;
		logic [3:0] nz0, wi;
		logic tst, pk;
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_sel <= psat_pkg::psat_op_e'(op);
		first_operand <= a;
		second_operand <= b;
		dest_given <= dg;
		dest_index <= di;
		first_src_index <= si;
		shifter_carry_valid <= cv;
		shifter_carry <= c;
		nz0 = core.nzcv_q;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
		tst = (op == 4'h8) || (op == 4'h9);
		pk = (op < 4'h8) || (op == 4'ha) || (op == 4'hb);
		ex = (op == 4'h8) ? (a & b) : (a ^ b);
		wi = dg ? di : si;
		chk("wr_en", 32'(pk), 32'(wr_en));
		chk("flag_nz_wr", 32'(tst), 32'(flag_nz_wr));
		chk("flag_c_wr", 32'(tst & cv), 32'(flag_c_wr));
		if (pk) chk("wr_data", exp_data(op, a, b), wr_data);
		if (pk) chk("wr_index", 32'(wi), 32'(wr_index));
		if (tst) chk("flag_n", 32'(ex[31]), 32'(flag_n));
		if (tst) chk("flag_z", 32'(ex == 32'h0), 32'(flag_z));
		if (tst && cv) chk("flag_c", 32'(c), 32'(flag_c));
		@(posedge sys_clk);
		#1;
		chk("strobes", 32'h0, {29'h0, wr_en, flag_nz_wr, flag_c_wr});
		chk("flag v", 32'h0, 32'(core.nzcv_q[0]));
		if (!tst) chk("flags kept", 32'(nz0), 32'(core.nzcv_q));
		if (pk) chk("reg file", exp_data(op, a, b), core.regs_q[wi]);
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#20000;
		error_cnt++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] ra, rb;
		int ro, rx;
		repeat (6) @(posedge sys_clk);
		chk("reset outputs", 32'h0, {wr_en, flag_nz_wr, flag_c_wr, wr_data[28:0]});
		rst <= 1'b0;
		issue(4'h4, 32'h00050003, 32'h00010004, 1'b1, 4'h3, 4'h1, 1'b0, 1'b0);
		issue(4'h0, 32'h7fff8000, 32'h7fff7fff, 1'b0, 4'h2, 4'h5, 1'b1, 1'b1);
		issue(4'h1, 32'h80007fff, 32'h7fff8000, 1'b1, 4'h6, 4'h0, 1'b0, 1'b0);
		issue(4'h3, 32'h807f0080, 32'h7f80ff7f, 1'b1, 4'h7, 4'h1, 1'b0, 1'b0);
		issue(4'h2, 32'h00007fff, 32'h00008000, 1'b1, 4'h5, 4'h1, 1'b0, 1'b0);
		issue(4'hb, 32'hff80ff01, 32'h01800101, 1'b1, 4'hc, 4'h2, 1'b0, 1'b0);
		issue(4'ha, 32'hffff8000, 32'h00018000, 1'b1, 4'h8, 4'h2, 1'b0, 1'b0);
		issue(4'h9, 32'h80000000, 32'h00000000, 1'b0, 4'h0, 4'h1, 1'b1, 1'b1);
		issue(4'h8, 32'h000000ff, 32'h00000100, 1'b0, 4'h0, 4'h1, 1'b1, 1'b0);
		issue(4'h9, 32'h1234abcd, 32'h1234abcd, 1'b1, 4'h4, 4'h1, 1'b0, 1'b1);
		for (int k = 12; k < 16; k++) begin
			issue(4'(k), 32'h11112222, 32'h33334444, 1'b1, 4'h9, 4'h1, 1'b1, 1'b1);
		end
		$display("Directed tests done");
		for (int n = 0; n < 300; n++) begin
			ra = $random(seed);
			rb = $random(seed);
			ro = $unsigned($random(seed)) % 12;
			rx = $unsigned($random(seed));
			issue(4'(ro), ra, rb, rx[0], 4'(rx[7:4] % 13), 4'(rx[11:8] % 13),
				rx[1], rx[2]);
		end
		$display("Random tests done");
		chk("index legal", 32'h0, 32'(core.bad_index_q));
		report_and_stop;
	end
endmodule
